/* bench/spi_port_asserts.sv */
// link checker: drive roles, select release, fault, sck edge spacing
// assumes instantiation beside the link interface in the bench top
`timescale 1ns/1ps
`default_nettype none

module spi_port_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sck,
   input wire logic ss_n,
   input wire logic dev_sck_oe,
   input wire logic dev_mosi_oe,
   input wire logic dev_miso_o,
   input wire logic dev_miso_oe,
   input wire logic dev_ss_oe,
   input wire logic host_sck_oe
);
   localparam int QUIET = 200;
   logic drv, drv_q, sck_q, edge_hit;
   logic [3:0] edge_cnt;
   logic [7:0] run, prev_run;
   assign drv = dev_sck_oe | host_sck_oe;
   assign edge_hit = drv & drv_q & (sck ^ sck_q);

   // edges since sck got a driver, cycles between edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sck_q <= 1'b1;
         drv_q <= 1'b0;
         edge_cnt <= 4'h0;
         run <= 8'h00;
         prev_run <= 8'h00;
      end else begin
         sck_q <= sck;
         drv_q <= drv;
         if (!drv)
            edge_cnt <= 4'h0;
         else if (edge_hit)
            edge_cnt <= edge_cnt + 4'h1;
         if (edge_hit) begin
            run <= 8'h01;
            prev_run <= run;
         end else if (run != 8'hff)
            run <= run + 8'h01;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_fault_seen;
      dev_sck_oe && !dev_ss_oe && !ss_n;
   endsequence
   sequence s_master_off;
      !dev_sck_oe && !dev_mosi_oe;
   endsequence
   sequence s_sel_held;
      (!ss_n && dev_miso_oe) [*3];
   endsequence

   a_slave_only_miso:
      assert property (dev_miso_oe |-> !dev_sck_oe && !dev_mosi_oe)
      else $error("slave drives a master pin");
   a_slave_sel_input:
      assert property (dev_miso_oe |-> !dev_ss_oe)
      else $error("slave drives its select pin");
   a_miso_needs_sel:
      assert property (ss_n [*2] |-> !dev_miso_oe)
      else $error("data out driven while deselected");
   a_deselect_release:
      assert property ($rose(ss_n) && !dev_ss_oe |=> !dev_miso_oe)
      else $error("data out held after deselect");
   a_fault_release:
      assert property (s_fault_seen |-> ##[0:2] s_master_off)
      else $error("master kept pins after select fault");
   a_byte_edges:
      assert property (run == QUIET |-> edge_cnt == 4'h0)
      else $error("sck stopped inside a byte");
   a_half_period_even:
      assert property (edge_hit && edge_cnt >= 4'h2 |-> run == prev_run)
      else $error("uneven sck half period");
   a_miso_on_edges:
      assert property (s_sel_held ##0 $changed(dev_miso_o) |->
         $changed(sck) || $past(sck) != $past(sck, 2)
         || $past(sck, 2) != $past(sck, 3))
      else $error("data out changed away from sck edges");
endmodule // spi_port_asserts

`default_nettype wire

/* bench/test_spi_master_slave_port.sv */
// bench: port as slave and master against the peer over the link
// assumes the defines header on the include path, one aclk for all
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_defines.svh"

module test_spi_master_slave_port;
   import spi_port_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, gie = 1'b1, ack = 1'b0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
   logic [4:0] pins = 5'h1f;
   logic xfer_irq, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic rready = 0, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp, r;
   int n_fail = 0, samples_checked = 0, n;
   logic [18:0] rows [4] = '{19'h0a53c, 19'h5815e, 19'h20fc2, 19'h76b90};
   int div_tab [8] = '{4, 16, 64, 128, 2, 8, 32, 64};

   spi_link_if link();
   spi_port_device i_spi_port_device (.aclk(aclk), .aresetn(aresetn),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .global_irq_enable(gie), .irq_vector_ack(ack), .xfer_irq(xfer_irq),
      .sck_dir_out(pins[4]), .mosi_dir_out(pins[3]),
      .miso_dir_out(pins[2]), .ss_dir_out(pins[1]),
      .ss_out_level(pins[0]), .link(link));
   spi_port_host i_spi_port_host (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(link));
   spi_port_asserts i_spi_port_asserts (.aclk(aclk), .aresetn(aresetn),
      .sck(link.sck), .ss_n(link.ss_n), .dev_sck_oe(link.dev_sck_oe),
      .dev_mosi_oe(link.dev_mosi_oe), .dev_miso_o(link.dev_miso_o),
      .dev_miso_oe(link.dev_miso_oe), .dev_ss_oe(link.dev_ss_oe),
      .host_sck_oe(link.host_sck_oe));

   always #4 aclk = ~aclk;

   task complete_run;
      if (n_fail == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task dwr(input logic [1:0] a, input logic [7:0] v);
      @(posedge aclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge aclk);
      reg_wr <= 1'b0;
   endtask

   task dchk(input string nm, input logic [1:0] a, input logic [7:0] e);
      @(posedge aclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge aclk);
      reg_rd <= 1'b0;
      @(posedge aclk);
      chk(nm, e, reg_rdata);
   endtask

   task awr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(negedge aclk); while (awready !== 1'b1);
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(negedge aclk); while (bvalid !== 1'b1);
      chk("axi bresp", `RESP_OKAY, bresp);
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   task ard(input logic [7:0] a, output logic [7:0] v, output logic [1:0] s);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      v = rdata[7:0];
      s = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   task wait_irq(output int k);
      k = 0;
      do begin
         @(negedge aclk);
         k++;
      end while (xfer_irq !== 1'b1 && k < 4000);
   endtask

   initial begin
      #200000;
      n_fail++;
      complete_run;
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      dchk("control", `REG_CONTROL, 8'h00);
      dchk("status", `REG_STATUS, 8'h00);
      dchk("unmapped", 2'h3, 8'h00);
      chk("dev drive", 4'h0, {link.dev_sck_oe, link.dev_mosi_oe,
         link.dev_miso_oe, link.dev_ss_oe});
      ard(8'h14, d, r);
      chk("axi resp", `RESP_SLVERR, r);
      awr(`H_HALF, 32'h3);
      foreach (rows[i]) begin
         dwr(`REG_CONTROL, {2'h3, rows[i][18], 1'b0, rows[i][17:16], 2'h0});
         dwr(`REG_DATA, rows[i][7:0]);
         awr(`H_CTRL, {29'h3, rows[i][18], rows[i][16], rows[i][17]});
         awr(`H_CTRL, {29'h2, rows[i][18], rows[i][16], rows[i][17]});
         awr(`H_TX, {24'h0, rows[i][15:8]});
         wait_irq(n);
         do ard(`H_STATUS, d, r); while (d[1] !== 1'b1);
         dchk("status", `REG_STATUS, 8'h80);
         dchk("rx byte", `REG_DATA, rows[i][15:8]);
         dchk("status", `REG_STATUS, 8'h00);
         ard(`H_RX, d, r);
         chk("host rx", rows[i][7:0], d);
         awr(`H_CTRL, 32'h0);
      end
      pins[0] <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         dwr(`REG_STATUS, {7'h0, i[2]});
         dwr(`REG_CONTROL, {6'h34, i[1:0]});
         dwr(`REG_DATA, 8'h3c);
         wait_irq(n);
         chk("sck span", 8 * div_tab[i] + 1, n);
         chk("select pin", 1'b0, link.ss_n);
         @(posedge aclk);
         ack <= 1'b1;
         @(posedge aclk);
         ack <= 1'b0;
         @(posedge aclk);
         chk("irq after ack", 1'b0, xfer_irq);
         dchk("master rx", `REG_DATA, 8'hff);
      end
      dwr(`REG_DATA, 8'h11);
      dwr(`REG_DATA, 8'h22);
      wait_irq(n);
      @(posedge aclk);
      gie <= 1'b0;
      @(posedge aclk);
      chk("irq masked", 1'b0, xfer_irq);
      dchk("status", `REG_STATUS, 8'hc1);
      dchk("master rx", `REG_DATA, 8'hff);
      dchk("status", `REG_STATUS, 8'h01);
      pins[1] <= 1'b0;
      awr(`H_CTRL, 32'h10);
      dchk("control", `REG_CONTROL, 8'hc3);
      dchk("status", `REG_STATUS, 8'h81);
      awr(`H_CTRL, 32'h0);
      dwr(`REG_CONTROL, 8'hd3);
      dchk("control", `REG_CONTROL, 8'hd3);
      complete_run;
   end
endmodule // test_spi_master_slave_port

`default_nettype wire

/* logic/spi_port_device.sv */
// serial port, master or slave, with control, status and data registers
// assumes a synchronous byte register port and link inputs synchronous
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_defines.svh"

module spi_port_device (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   output logic xfer_irq,
   input wire logic sck_dir_out,
   input wire logic mosi_dir_out,
   input wire logic miso_dir_out,
   input wire logic ss_dir_out,
   input wire logic ss_out_level,
   spi_link_if.dev_end link
);
   import spi_port_pkg::*;

   spi_port_pkg::dev_state_t s, n;
   logic en, mst, slv, clock_idle_level, clock_sample_edge, lsb, busy, tick;
   logic edge_ev, lead, sample, last, din, fault;
   logic [7:0] sampled;

   assign en = s.ctrl[`CTL_PORT_EN];
   assign mst = en & s.ctrl[`CTL_MASTER];
   assign slv = en & ~s.ctrl[`CTL_MASTER];
   assign clock_idle_level = s.ctrl[`CTL_IDLE_LVL];
   assign clock_sample_edge = s.ctrl[`CTL_SAMPLE_EDGE];
   assign lsb = s.ctrl[`CTL_BIT_ORDER];
   assign busy = (s.phase == LINK_SHIFT) | (s.edges != 4'h0);
   assign tick = (s.phase == LINK_SHIFT) & (s.divcnt == half_last(s.dbl,
                 {s.ctrl[`CTL_RATE_HI], s.ctrl[`CTL_RATE_LO]}));
   // slave relies on sck at most a quarter of aclk
   assign edge_ev = mst ? tick
                  : slv & ~link.ss_n & (link.sck != s.sck_prev);
   // leading edge leaves the idle level
   assign lead = mst ? (s.sck_lvl == clock_idle_level) : (link.sck != clock_idle_level);
   assign sample = lead ^ clock_sample_edge;
   assign din = mst ? link.miso : link.mosi;
   assign sampled = shift_in(s.shifter, lsb, din);
   assign last = mst ? (s.edges == `EDGE_LAST)
               : sample & (s.edges[3:1] == `SAMPLE_LAST);
   assign fault = mst & ~ss_dir_out & ~link.ss_n;

   always_comb begin
      n = s;
      n.sck_prev = link.sck;
      // register reads, data read gives the buffer
      if (reg_rd) begin
         case (reg_addr)
            `REG_CONTROL: n.rdata = s.ctrl;
            `REG_STATUS: n.rdata = {s.done, s.coll, `STS_RESERVED, s.dbl};
            `REG_DATA: n.rdata = s.rxbuf;
            default: n.rdata = 8'h00;
         endcase
      end
      // flag clearing first, so a setting event wins below
      if ((reg_rd | reg_wr) & (reg_addr == `REG_DATA)) begin
         n.done = s.done & ~s.done_armed;
         n.coll = s.coll & ~s.coll_armed;
         n.done_armed = 1'b0;
         n.coll_armed = 1'b0;
      end
      if (reg_rd & (reg_addr == `REG_STATUS)) begin
         n.done_armed = s.done | s.coll;
         n.coll_armed = s.coll;
      end
      if (irq_vector_ack) begin
         n.done = 1'b0;
      end
      if (reg_wr & (reg_addr == `REG_CONTROL)) begin
         n.ctrl = reg_wdata;
      end
      if (reg_wr & (reg_addr == `REG_STATUS)) begin
         n.dbl = reg_wdata[`STS_DOUBLE];
      end
      // idle slave presents its first bit
      if (slv & (s.edges == 4'h0)) begin
         n.dout = out_bit(s.shifter, lsb);
      end
      // master clock generator
      if (s.phase == LINK_SHIFT) begin
         if (tick) begin
            n.divcnt = 7'h00;
            n.sck_lvl = ~s.sck_lvl;
         end else begin
            n.divcnt = s.divcnt + 7'h01;
         end
      end else begin
         // new idle level at once, no stray edge when drive starts
         n.sck_lvl = n.ctrl[`CTL_IDLE_LVL];
      end
      // shift on one edge, latch on the other
      if (edge_ev) begin
         if (sample) begin
            n.shifter = sampled;
         end else begin
            n.dout = out_bit(s.shifter, lsb);
         end
         n.edges = s.edges + 4'h1;
         if (last) begin
            n.rxbuf = sample ? sampled : s.shifter;
            n.done = 1'b1;
            n.phase = LINK_IDLE;
            n.edges = 4'h0;
            n.sck_lvl = clock_idle_level;
         end
      end
      // deselected slave drops its partial byte
      if (slv & link.ss_n) begin
         n.edges = 4'h0;
         if (s.edges != 4'h0) begin
            n.shifter = 8'h00;
         end
      end
      // data write loads and starts, or collides
      if (reg_wr & (reg_addr == `REG_DATA)) begin
         if (busy & en) begin
            n.coll = 1'b1;
         end else begin
            n.shifter = reg_wdata;
            n.dout = out_bit(reg_wdata, lsb);
            n.edges = 4'h0;
            if (mst) begin
               n.phase = LINK_SHIFT;
               n.divcnt = 7'h00;
            end
         end
      end
      // select driven low against a master
      if (fault) begin
         n.ctrl[`CTL_MASTER] = 1'b0;
         n.done = 1'b1;
         n.phase = LINK_IDLE;
         n.edges = 4'h0;
         n.sck_lvl = clock_idle_level;
      end
      if (~en) begin
         n.phase = LINK_IDLE;
         n.edges = 4'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign reg_rdata = s.rdata;
   assign xfer_irq = s.ctrl[`CTL_IRQ_EN] & s.done & global_irq_enable;
   assign link.dev_sck_o = s.sck_lvl;
   assign link.dev_sck_oe = mst & sck_dir_out;
   assign link.dev_mosi_o = s.dout;
   assign link.dev_mosi_oe = mst & mosi_dir_out;
   assign link.dev_miso_o = s.dout;
   assign link.dev_miso_oe = slv & ~link.ss_n & miso_dir_out;
   assign link.dev_ss_o = ss_out_level;
   assign link.dev_ss_oe = mst & ss_dir_out;
endmodule // spi_port_device

`default_nettype wire

/* logic/spi_port_host.sv */
// peer serial master steered by software over AXI4-Lite
// assumes one aclk shared with the port; 32-bit aligned registers
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_defines.svh"

module spi_port_host (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   spi_link_if.host_end link
);
   import spi_port_pkg::*;

   spi_port_pkg::host_state_t s, n;
   logic wr_go, rd_go, tick, lead, sample, clock_idle_level, lsb;
   logic [7:0] half, sampled;

   assign wr_go = awvalid & wvalid & ~s.bvalid;
   assign rd_go = arvalid & ~s.rvalid;
   // half period never under two clocks
   assign half = (s.half < `H_HALF_MIN) ? `H_HALF_MIN : s.half;
   assign tick = (s.phase == LINK_SHIFT) & (s.divcnt == half - 8'h01);
   assign clock_idle_level = s.ctrl[`H_IDLE_LVL];
   assign lsb = s.ctrl[`H_LSB_FIRST];
   assign lead = (s.sck_lvl == clock_idle_level);
   assign sample = lead ^ s.ctrl[`H_SAMPLE_EDGE];
   assign sampled = shift_in(s.shifter, lsb, link.miso);

   always_comb begin
      n = s;
      if (s.bvalid & bready) begin
         n.bvalid = 1'b0;
      end
      if (s.rvalid & rready) begin
         n.rvalid = 1'b0;
      end
      if (rd_go) begin
         n.rvalid = 1'b1;
         n.rresp = `RESP_OKAY;
         case (araddr)
            `H_CTRL: n.rdata = {27'h0, s.ctrl};
            `H_HALF: n.rdata = {24'h0, s.half};
            `H_RX: begin
               n.rdata = {24'h0, s.rxbuf};
               n.done = 1'b0;
            end
            `H_STATUS: n.rdata = {30'h0, s.done, s.phase == LINK_SHIFT};
            default: begin
               n.rdata = 32'h0;
               n.rresp = `RESP_SLVERR;
            end
         endcase
      end
      if (wr_go) begin
         n.bvalid = 1'b1;
         n.bresp = `RESP_OKAY;
         case (awaddr)
            `H_CTRL: if (wstrb[0]) n.ctrl = wdata[4:0];
            `H_HALF: if (wstrb[0]) n.half = wdata[7:0];
            `H_TX: begin
               if (wstrb[0] & (s.phase == LINK_IDLE)) begin
                  n.shifter = wdata[7:0];
                  n.dout = out_bit(wdata[7:0], lsb);
                  n.phase = LINK_SHIFT;
                  n.divcnt = 8'h00;
                  n.edges = 4'h0;
               end
            end
            `H_RX, `H_STATUS: n.bresp = `RESP_OKAY;
            default: n.bresp = `RESP_SLVERR;
         endcase
      end
      if (s.phase == LINK_SHIFT) begin
         if (tick) begin
            n.divcnt = 8'h00;
            n.sck_lvl = ~s.sck_lvl;
            if (sample) begin
               n.shifter = sampled;
            end else begin
               n.dout = out_bit(s.shifter, lsb);
            end
            n.edges = s.edges + 4'h1;
            if (s.edges == `EDGE_LAST) begin
               n.rxbuf = sample ? sampled : s.shifter;
               n.done = 1'b1;
               n.phase = LINK_IDLE;
               n.edges = 4'h0;
            end
         end else begin
            n.divcnt = s.divcnt + 8'h01;
         end
      end else begin
         // follow a new idle level at once, no stray edge on enable
         n.sck_lvl = n.ctrl[`H_IDLE_LVL];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign awready = wr_go;
   assign wready = wr_go;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = ~s.rvalid;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign link.host_sck_o = s.sck_lvl;
   assign link.host_sck_oe = s.ctrl[`H_DRIVE];
   assign link.host_mosi_o = s.dout;
   assign link.host_mosi_oe = s.ctrl[`H_DRIVE];
   assign link.host_ss_o = s.ctrl[`H_SEL_LVL];
   assign link.host_ss_oe = s.ctrl[`H_DRIVE];
endmodule // spi_port_host

`default_nettype wire

/* shared/spi_link_if.sv */
// four-wire serial link between the port and its peer
// assumes both ends run on the same aclk; undriven wires pull high
`timescale 1ns/1ps
`default_nettype none

interface spi_link_if;
   logic sck, mosi, miso, ss_n;
   logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe;
   logic dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe;
   logic host_sck_o, host_sck_oe, host_mosi_o, host_mosi_oe;
   logic host_ss_o, host_ss_oe;

   // wire resolution from enables
   assign sck = dev_sck_oe ? dev_sck_o : host_sck_oe ? host_sck_o : 1'b1;
   assign mosi = dev_mosi_oe ? dev_mosi_o
                : host_mosi_oe ? host_mosi_o : 1'b1;
   assign miso = dev_miso_oe ? dev_miso_o : 1'b1;
   assign ss_n = dev_ss_oe ? dev_ss_o : host_ss_oe ? host_ss_o : 1'b1;

   modport dev_end (
      input sck, mosi, miso, ss_n,
      output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
      output dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe
   );

   modport host_end (
      input sck, mosi, miso, ss_n,
      output host_sck_o, host_sck_oe, host_mosi_o, host_mosi_oe,
      output host_ss_o, host_ss_oe
   );
endinterface

`default_nettype wire

/* shared/spi_port_defines.svh */
// constants of the serial port pair: register map, bit fields, divisors
// assumes inclusion by both ends and by the package
//
// Notes on behaviour
// - slave: select input; low selects, drives data-out if allowed
// - slave: select high resets counter, drops partial byte
// - master, select as output: plain output pin
// - master, select input low: fault, become slave, set done
// - software rechecks master bit after fault, sets it again
// - irq enable bit 7 raises interrupt on done flag
// - port enable bit 6 gates all operation and pins
// - bit order bit 5: one means lsb first
// - master select bit 4; hardware clears it on fault
// - idle level bit 3 sets clock idle level
// - sample edge bit 2: zero samples leading edge
// - rate bits and double rate divide system clock
// - double rate bit 0 of status doubles clock
// - external master keeps clock at most quarter rate
// - done flag bit 7 set on byte end or fault
// - done cleared by vector, or status read then data access
// - collision flag bit 6 on data write while busy
// - status bits 5 to 1 read zero
// - data write loads shifter and starts; read gives buffer
// - shift and latch on opposite edges; modes 0 to 3
// - master: write starts clock, eight bits, stop, flag
// - transmit single buffered, receive double buffered
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

// device register port, 2-bit address
`define REG_CONTROL 2'h0
`define REG_STATUS 2'h1
`define REG_DATA 2'h2

// control fields
`define CTL_IRQ_EN 7
`define CTL_PORT_EN 6
`define CTL_BIT_ORDER 5
`define CTL_MASTER 4
`define CTL_IDLE_LVL 3
`define CTL_SAMPLE_EDGE 2
`define CTL_RATE_HI 1
`define CTL_RATE_LO 0

// status fields
`define STS_DONE 7
`define STS_COLLISION 6
`define STS_DOUBLE 0
`define STS_RESERVED 5'h00

// sck divisors, normal then double speed
`define DIV_N0 8'h04
`define DIV_N1 8'h10
`define DIV_N2 8'h40
`define DIV_N3 8'h80
`define DIV_D0 8'h02
`define DIV_D1 8'h08
`define DIV_D2 8'h20
`define DIV_D3 8'h40

`define EDGE_LAST 4'hf
`define SAMPLE_LAST 3'h7

// host controller over AXI4-Lite
`define H_CTRL 8'h00
`define H_HALF 8'h04
`define H_TX 8'h08
`define H_RX 8'h0c
`define H_STATUS 8'h10
`define H_IDLE_LVL 0
`define H_SAMPLE_EDGE 1
`define H_LSB_FIRST 2
`define H_SEL_LVL 3
`define H_DRIVE 4
`define H_HALF_MIN 8'h02
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* shared/spi_port_pkg.sv */
// types and shared helpers of the serial port pair
// assumes the defines header is on the include path
`include "spi_port_defines.svh"

package spi_port_pkg;

   typedef enum logic [0:0] {
      LINK_IDLE = 1'b0,
      LINK_SHIFT = 1'b1
   } link_phase_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic dbl;
      logic done;
      logic coll;
      logic done_armed;
      logic coll_armed;
      link_phase_t phase;
      logic [7:0] shifter;
      logic [7:0] rxbuf;
      logic [3:0] edges;
      logic [6:0] divcnt;
      logic sck_lvl;
      logic sck_prev;
      logic dout;
      logic [7:0] rdata;
   } dev_state_t;

   typedef struct packed {
      logic [4:0] ctrl;
      logic [7:0] half;
      link_phase_t phase;
      logic [7:0] shifter;
      logic [7:0] rxbuf;
      logic [3:0] edges;
      logic [7:0] divcnt;
      logic sck_lvl;
      logic dout;
      logic done;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } host_state_t;

   function automatic logic out_bit(input logic [7:0] d, input logic lsb);
      return lsb ? d[0] : d[7];
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] d,
                                           input logic lsb, input logic b);
      return lsb ? {b, d[7:1]} : {d[6:0], b};
   endfunction

   // last count of one sck half period
   function automatic logic [6:0] half_last(input logic dbl,
                                            input logic [1:0] rate);
      logic [7:0] d;
      d = `DIV_N0;
      case ({dbl, rate})
         3'h0: d = `DIV_N0;
         3'h1: d = `DIV_N1;
         3'h2: d = `DIV_N2;
         3'h3: d = `DIV_N3;
         3'h4: d = `DIV_D0;
         3'h5: d = `DIV_D1;
         3'h6: d = `DIV_D2;
         default: d = `DIV_D3;
      endcase
      return 7'((d >> 1) - 8'h01);
   endfunction

endpackage
